// *** tb/bank_monitor.sv ***
// Purpose: bus and field placement checks for the profile two bank
// Assumes: byte address is four times the register index
// Notes: a field shows its byte two edges after the bus ack
`timescale 1ns/1ns
module bank_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register bus
  input wire logic [12:0] avs_address,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  // settings
  input wire bk_pkg::coef_t coef,
  input wire bk_pkg::div_cfg_t div_cfg,
  input wire bk_pkg::lock_cfg_t lock_cfg
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [7:0] wd_q1;
  logic [7:0] wd_q2;
  // plain pipe, so a field is compared with the byte written
  always_ff @(posedge clk) begin
    wd_q1 <= avs_writedata[7:0];
    wd_q2 <= wd_q1;
  end
  sequence wr_at(logic [10:0] idx);
    avs_write && !avs_waitrequest && avs_byteenable[0] &&
      avs_address == {idx, 2'b00};
  endsequence
  AST_ACK_ONE: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("ack held longer than one cycle");
  AST_COEF_A: assert property (wr_at(bk_pkg::COEF_A_MANT_LO) |-> ##2
    coef.a_mant[7:0] == wd_q2) else $error("coef a low byte");
  AST_COEF_B: assert property (wr_at(bk_pkg::COEF_B_MANT_LOW_MIX) |-> ##2
    {coef.b_mant[6:0], coef.a_exp2[2]} == wd_q2) else $error("coef b");
  AST_COEF_C: assert property (wr_at(bk_pkg::COEF_C_EXP_MANT_TOP) |-> ##2
    {coef.c_exp, coef.c_mant[16]} == wd_q2[5:0]) else $error("coef c");
  AST_COEF_D: assert property (wr_at(bk_pkg::COEF_D_MANT_HI_MIX) |-> ##2
    {coef.d_exp[0], coef.d_mant[14:8]} == wd_q2) else $error("coef d");
  AST_EXP_MIX: assert property (wr_at(bk_pkg::COEF_EXP_MIX) |-> ##2
    {coef.a_exp3, coef.d_exp[4:1]} == wd_q2) else $error("exp mix");
  AST_FRAC: assert property (wr_at(bk_pkg::FB_FRAC_MIXED) |-> ##2
    {div_cfg.frac_num[3:0], div_cfg.frac_mod[9:8]} ==
    {wd_q2[7:4], wd_q2[1:0]}) else $error("fraction byte");
  AST_PRE_TOP: assert property (wr_at(bk_pkg::PRESCALE_DIV_BYTE3) |-> ##2
    div_cfg.prescale[29:24] == wd_q2[5:0]) else $error("prescale top");
  AST_FB_TOP: assert property (wr_at(bk_pkg::FB_INT_DIV_BYTE2) |-> ##2
    div_cfg.fb_int[19:16] == wd_q2[3:0]) else $error("feedback top");
  AST_SCALE: assert property ($stable(lock_cfg.ph_limit) &&
    $stable(lock_cfg.ph_scale_ns) |-> lock_cfg.ph_limit_ps ==
    (lock_cfg.ph_scale_ns ? 32'(lock_cfg.ph_limit) * 32'd1000 :
    32'(lock_cfg.ph_limit))) else $error("phase limit scaling");
endmodule
bind dpll_profile_two_param_bank bank_monitor i_bank_monitor (
  .clk(clk), .reset_n(reset_n), .avs_address(avs_address),
  .avs_write(avs_write), .avs_byteenable(avs_byteenable),
  .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
  .coef(coef), .div_cfg(div_cfg), .lock_cfg(lock_cfg));

// *** tb/dpll_profile_two_param_bank_tb_top.sv ***
// Purpose: register, divider, timer and lock checks for profile two
// Assumes: registers reset to zero except status, which reads 0x04; one wait state per access
// Notes: short ms and lock-full values keep the run brief
`timescale 1ns/1ns
module dpll_profile_two_param_bank_tb_top;
  logic clk, reset_n, rd, wr, waitreq, ref_tick, vco_tick, pv, fv;
  logic prescale_tick, feedback_tick, phase_locked, freq_locked, ms_tick;
  logic [12:0] addr;
  logic [3:0] be;
  logic [31:0] wd, rdata, pe, q, k1, k2, k3;
  logic [23:0] fe;
  logic [7:0] p [1672:1713];
  logic [10:0] ci [8] = '{11'h69e, 11'h6a2, 11'h6a9, 11'h6ab, 11'h6ac,
    11'h6ad, 11'h6b0, 11'h6b1};
  logic [7:0] cv [8] = '{8'h02, 8'h07, 8'h64, 8'h08, 8'h10, 8'h64, 8'h08,
    8'h10};
  int miscompares, tests_run;
  bk_pkg::coef_t coef;
  bk_pkg::div_cfg_t dc;
  bk_pkg::lock_cfg_t lc;
  bk_pkg::qual_cfg_t qc;
  dpll_profile_two_param_bank #(.MS_CYCLES(10), .LOCK_FULL(16'h0010))
    i_dpll_profile_two_param_bank (.clk(clk), .reset_n(reset_n),
    .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_byteenable(be), .avs_writedata(wd), .avs_readdata(rdata),
    .avs_waitrequest(waitreq), .ref_tick(ref_tick), .vco_tick(vco_tick),
    .phase_err_valid(pv), .phase_err_ps(pe), .freq_err_valid(fv),
    .freq_err_ps(fe), .prescale_tick(prescale_tick),
    .feedback_tick(feedback_tick), .phase_locked(phase_locked),
    .freq_locked(freq_locked), .ms_tick(ms_tick), .coef(coef),
    .div_cfg(dc), .lock_cfg(lc), .qual_cfg(qc));
  function automatic logic [7:0] msk(logic [10:0] i);
    case (i)
      11'h68a, 11'h68d, 11'h6a4: return 8'h0f;
      11'h697: return 8'h7f;
      11'h69a, 11'h6a1, 11'h6a8: return 8'h3f;
      11'h6a7: return 8'hf3;
      11'h6a5: return 8'h00;
      default: return 8'hff;
    endcase
  endfunction
  task automatic test_done;
    $display("mismatches %0d of %0d checks", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // holds the request until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [10:0] i,
    input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= {i, 2'b00};
    wd <= {24'h0, d};
    do begin
      @(posedge clk);
      k++;
    end while (waitreq !== 1'b0 && k < 50);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (k >= 50) begin
      miscompares++;
      $display("[FAIL] %0t bus wait timed out", $time);
      test_done();
    end
  endtask
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  initial begin
    reset_n = 0;
    rd = 0;
    wr = 0;
    be = 4'h1;
    addr = 0;
    wd = 0;
    pe = 0;
    ref_tick = 0;
    vco_tick = 0;
    pv = 0;
    fv = 0;
    fe = 0;
    miscompares = 0;
    tests_run = 0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 'h680; i <= 'h6b2; i++) begin
      bus(1'b0, 11'(i), 8'h00);
      chk(q, i == 'h6b2 ? 32'h4 : 32'h0);
    end
    for (int i = 'h688; i <= 'h6b1; i++) begin
      p[i] = 8'(i * 37 + 5);
      bus(1'b1, 11'(i), p[i]);
    end
    for (int i = 'h688; i <= 'h6b1; i++) begin
      bus(1'b0, 11'(i), 8'h00);
      chk(q, {24'h0, p[i] & msk(11'(i))});
    end
    chk(32'(dc.prescale), {2'b0, p['h6a1][5:0], p['h6a0], p['h69f],
      p['h69e]});
    chk(32'(dc.fb_int), {12'h0, p['h6a4][3:0], p['h6a3], p['h6a2]});
    chk(32'({dc.frac_num, dc.frac_mod}), 32'({p['h6a8][5:0], p['h6a7][7:4],
      p['h6a7][1:0], p['h6a6]}));
    chk(32'(coef.a_mant), {16'h0, p['h693], p['h692]});
    chk(32'(coef.b_mant), 32'({p['h697][1:0], p['h696],
      p['h695][7:1]}));
    chk(32'(coef.c_mant), 32'({p['h69a][0], p['h699], p['h698]}));
    chk(32'(coef.d_mant), 32'({p['h69c][6:0], p['h69b]}));
    chk(32'({coef.a_exp1, coef.a_exp2, coef.a_exp3}), 32'({p['h694][5:0],
      p['h695][0], p['h694][7:6], p['h69d][7:4]}));
    chk(32'({coef.b_exp, coef.c_exp}), 32'({p['h697][6:2],
      p['h69a][5:1]}));
    chk(32'(coef.d_exp), 32'({p['h69d][3:0], p['h69c][7]}));
    chk(32'(lc.ph_limit), {16'h0, p['h6aa], p['h6a9]});
    chk(32'({lc.ph_fill, lc.ph_drain}), {16'h0, p['h6ab], p['h6ac]});
    chk(32'(lc.fr_limit_ps), {8'h0, p['h6af], p['h6ae], p['h6ad]});
    chk(32'({lc.fr_fill, lc.fr_drain}), {16'h0, p['h6b0], p['h6b1]});
    chk({qc.qualify_ms, qc.recheck_ms}, {p['h68f], p['h68e], p['h691],
      p['h690]});
    chk(32'(qc.inner), 32'({p['h68a][3:0], p['h689], p['h688]}));
    chk(32'(qc.outer), 32'({p['h68d][3:0], p['h68c], p['h68b]}));
    for (int s = 1; s >= 0; s--) begin
      bus(1'b1, 11'h680, {s[0], 7'h0});
      repeat (3) @(posedge clk);
      chk({lc.ph_scale_ns, lc.ph_limit_ps[30:0]}, {s[0], 31'({16'h0,
        p['h6aa], p['h6a9]} * (s ? 32'd1000 : 32'd1))});
    end
    // unmapped place and a disabled byte lane must leave state alone
    bus(1'b1, 11'h6b3, 8'hff);
    bus(1'b0, 11'h6b3, 8'h00);
    chk(q, 32'h0);
    be <= 4'h0;
    bus(1'b1, 11'h6ac, 8'h00);
    be <= 4'h1;
    bus(1'b0, 11'h6ac, 8'h00);
    chk(q, {24'h0, p['h6ac]});
    for (int i = 'h69e; i <= 'h6b1; i++) bus(1'b1, 11'(i), 8'h00);
    for (int j = 0; j < 8; j++) bus(1'b1, ci[j], cv[j]);
    bus(1'b0, 11'h6b2, 8'h00);
    chk(32'(q[2]), 32'h0);
    k1 = 0;
    k2 = 0;
    k3 = 0;
    for (int c = 0; c < 30; c++) begin
      @(posedge clk);
      ref_tick <= c < 24;
      vco_tick <= c < 24;
      k1 += prescale_tick;
      k2 += feedback_tick;
      k3 += ms_tick;
    end
    chk(k1, 32'd8);
    chk(k2, 32'd3);
    chk(k3, 32'd3);
    // two fills reach the full level, one drain empties it
    for (int j = 0; j < 3; j++) begin
      @(posedge clk);
      pv <= 1'b1;
      fv <= 1'b1;
      pe <= j < 2 ? 32'd50 : 32'd200;
      fe <= j < 2 ? 24'd50 : 24'd200;
      @(posedge clk);
      pv <= 1'b0;
      fv <= 1'b0;
      repeat (3) @(posedge clk);
      chk(32'({phase_locked, freq_locked}), j == 1 ? 32'h3 : 32'h0);
    end
    test_done();
  end
endmodule

// *** verilog/bk_pkg.sv ***
// Purpose: shared constants and carriers for the profile two bank
// Assumes: byte registers, one per aligned 32-bit word (byte addr = idx*4)
// Notes: offsets below are register indexes, not byte addresses
package bk_pkg;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 32;
  localparam int IDX_W = 11;
  // register indexes
  localparam logic [10:0] PHASE_SCALE = 11'h680;
  localparam logic [10:0] INNER_LIMIT_BYTE0 = 11'h688;
  localparam logic [10:0] INNER_LIMIT_BYTE1 = 11'h689;
  localparam logic [10:0] INNER_LIMIT_BYTE2 = 11'h68a;
  localparam logic [10:0] OUTER_LIMIT_BYTE0 = 11'h68b;
  localparam logic [10:0] OUTER_LIMIT_BYTE1 = 11'h68c;
  localparam logic [10:0] OUTER_LIMIT_BYTE2 = 11'h68d;
  localparam logic [10:0] QUALIFY_TIME_LO = 11'h68e;
  localparam logic [10:0] QUALIFY_TIME_HI = 11'h68f;
  localparam logic [10:0] RECHECK_TIME_LO = 11'h690;
  localparam logic [10:0] RECHECK_TIME_HI = 11'h691;
  localparam logic [10:0] COEF_A_MANT_LO = 11'h692;
  localparam logic [10:0] COEF_A_MANT_HI = 11'h693;
  localparam logic [10:0] COEF_A_EXPONENTS = 11'h694;
  localparam logic [10:0] COEF_B_MANT_LOW_MIX = 11'h695;
  localparam logic [10:0] COEF_B_MANT_MID = 11'h696;
  localparam logic [10:0] COEF_B_EXP_MANT_TOP = 11'h697;
  localparam logic [10:0] COEF_C_MANT_LO = 11'h698;
  localparam logic [10:0] COEF_C_MANT_MID = 11'h699;
  localparam logic [10:0] COEF_C_EXP_MANT_TOP = 11'h69a;
  localparam logic [10:0] COEF_D_MANT_LO = 11'h69b;
  localparam logic [10:0] COEF_D_MANT_HI_MIX = 11'h69c;
  localparam logic [10:0] COEF_EXP_MIX = 11'h69d;
  localparam logic [10:0] PRESCALE_DIV_BYTE0 = 11'h69e;
  localparam logic [10:0] PRESCALE_DIV_BYTE1 = 11'h69f;
  localparam logic [10:0] PRESCALE_DIV_BYTE2 = 11'h6a0;
  localparam logic [10:0] PRESCALE_DIV_BYTE3 = 11'h6a1;
  localparam logic [10:0] FB_INT_DIV_BYTE0 = 11'h6a2;
  localparam logic [10:0] FB_INT_DIV_BYTE1 = 11'h6a3;
  localparam logic [10:0] FB_INT_DIV_BYTE2 = 11'h6a4;
  localparam logic [10:0] FB_INT_DIV_SPARE = 11'h6a5;
  localparam logic [10:0] FB_FRAC_MODULUS_LO = 11'h6a6;
  localparam logic [10:0] FB_FRAC_MIXED = 11'h6a7;
  localparam logic [10:0] FB_FRAC_NUMER_HI = 11'h6a8;
  localparam logic [10:0] PHASE_LOCK_LIMIT_LO = 11'h6a9;
  localparam logic [10:0] PHASE_LOCK_LIMIT_HI = 11'h6aa;
  localparam logic [10:0] PHASE_LOCK_FILL = 11'h6ab;
  localparam logic [10:0] PHASE_LOCK_DRAIN = 11'h6ac;
  localparam logic [10:0] FREQ_LOCK_LIMIT_BYTE0 = 11'h6ad;
  localparam logic [10:0] FREQ_LOCK_LIMIT_BYTE1 = 11'h6ae;
  localparam logic [10:0] FREQ_LOCK_LIMIT_BYTE2 = 11'h6af;
  localparam logic [10:0] FREQ_LOCK_FILL = 11'h6b0;
  localparam logic [10:0] FREQ_LOCK_DRAIN = 11'h6b1;
  localparam logic [10:0] BANK_STATUS = 11'h6b2;
  // field layout and values
  localparam int SCALE_BIT = 7;
  localparam int ST_PHASE_LOCK = 0;
  localparam int ST_FREQ_LOCK = 1;
  localparam int ST_FB_LOW = 2;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] MASK_FULL = 8'hff;
  localparam logic [7:0] MASK_LOW4 = 8'h0f;
  localparam logic [7:0] MASK_LOW6 = 8'h3f;
  localparam logic [7:0] MASK_LOW7 = 8'h7f;
  localparam logic [7:0] MASK_NONE = 8'h00;
  localparam logic [7:0] MASK_FRAC_MIX = 8'hf3;
  localparam logic [7:0] MASK_SCALE = 8'h80;
  localparam logic [19:0] FB_INT_MIN = 20'h00007;
  localparam logic [31:0] PS_PER_NS = 32'h000003e8;
  // timing
  localparam int CLK_HZ = 250000000;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYCLES = CLK_HZ / MS_PER_S;

  typedef enum {BUS_IDLE, BUS_ACK} bus_state_t;

  typedef struct packed {
    logic [15:0] a_mant;
    logic [5:0] a_exp1;
    logic [2:0] a_exp2;
    logic [3:0] a_exp3;
    logic [16:0] b_mant;
    logic [4:0] b_exp;
    logic [16:0] c_mant;
    logic [4:0] c_exp;
    logic [14:0] d_mant;
    logic [4:0] d_exp;
  } coef_t;

  typedef struct packed {
    logic [29:0] prescale;
    logic [19:0] fb_int;
    logic [9:0] frac_mod;
    logic [9:0] frac_num;
  } div_cfg_t;

  typedef struct packed {
    logic [15:0] ph_limit;
    logic ph_scale_ns;
    logic [31:0] ph_limit_ps;
    logic [7:0] ph_fill;
    logic [7:0] ph_drain;
    logic [23:0] fr_limit_ps;
    logic [7:0] fr_fill;
    logic [7:0] fr_drain;
  } lock_cfg_t;

  typedef struct packed {
    logic [19:0] inner;
    logic [19:0] outer;
    logic [15:0] qualify_ms;
    logic [15:0] recheck_ms;
  } qual_cfg_t;
endpackage

// *** verilog/dpll_profile_two_param_bank.sv ***
// Purpose: profile two register bank with dividers and lock detectors
// Assumes: Avalon-MM byte address, one register per aligned word
// Notes: data sits in bits [7:0]; unused bits store and read as zero
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
module dpll_profile_two_param_bank #(
  parameter int MS_CYCLES = bk_pkg::MS_CYCLES,
  parameter logic [15:0] LOCK_FULL = 16'h0400
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // avalon-mm slave
  input wire logic [bk_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [bk_pkg::DATA_W-1:0] avs_writedata,
  output logic [bk_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // loop datapath events
  input wire logic ref_tick,
  input wire logic vco_tick,
  input wire logic phase_err_valid,
  input wire logic [31:0] phase_err_ps,
  input wire logic freq_err_valid,
  input wire logic [23:0] freq_err_ps,
  // divided events and lock state
  output logic prescale_tick,
  output logic feedback_tick,
  output logic phase_locked,
  output logic freq_locked,
  output logic ms_tick,
  // settings for the loop
  output bk_pkg::coef_t coef,
  output bk_pkg::div_cfg_t div_cfg,
  output bk_pkg::lock_cfg_t lock_cfg,
  output bk_pkg::qual_cfg_t qual_cfg
);
  if (MS_CYCLES < 1) begin : g_chk
    $error("bank: MS_CYCLES must be positive");
  end
  if (LOCK_FULL == 16'h0000) begin : g_chk_full
    $error("bank: LOCK_FULL must be nonzero");
  end

  // register storage, indexed by register index
  logic [7:0] regs_ff [bk_pkg::INNER_LIMIT_BYTE0:bk_pkg::FREQ_LOCK_DRAIN];
  logic [7:0] nxt_regs [bk_pkg::INNER_LIMIT_BYTE0:bk_pkg::FREQ_LOCK_DRAIN];
  logic scale_ff, nxt_scale;

  // bus state
  bk_pkg::bus_state_t state_ff, nxt_state;
  logic wait_ff, nxt_wait;
  logic [bk_pkg::DATA_W-1:0] rdata_ff, nxt_rdata;
  logic [bk_pkg::IDX_W-1:0] idx;
  logic aligned;
  logic [7:0] rd_byte;
  logic [7:0] status;

  // settings shadow
  bk_pkg::coef_t coef_ff, nxt_coef;
  bk_pkg::div_cfg_t div_ff, nxt_div;
  bk_pkg::lock_cfg_t lock_ff, nxt_lock;
  bk_pkg::qual_cfg_t qual_ff, nxt_qual;
  logic fb_low_ff, nxt_fb_low;

  // millisecond strobe
  logic [31:0] ms_cnt_ff, nxt_ms_cnt;
  logic ms_ff, nxt_ms;

  // writable bits of each index; unused bits stay zero
  function automatic logic [7:0] wmask(input logic [10:0] i);
    case (i)
      bk_pkg::INNER_LIMIT_BYTE2: wmask = bk_pkg::MASK_LOW4;
      bk_pkg::OUTER_LIMIT_BYTE2: wmask = bk_pkg::MASK_LOW4;
      bk_pkg::COEF_B_EXP_MANT_TOP: wmask = bk_pkg::MASK_LOW7;
      bk_pkg::COEF_C_EXP_MANT_TOP: wmask = bk_pkg::MASK_LOW6;
      bk_pkg::PRESCALE_DIV_BYTE3: wmask = bk_pkg::MASK_LOW6;
      bk_pkg::FB_INT_DIV_BYTE2: wmask = bk_pkg::MASK_LOW4;
      bk_pkg::FB_INT_DIV_SPARE: wmask = bk_pkg::MASK_NONE;
      bk_pkg::FB_FRAC_MIXED: wmask = bk_pkg::MASK_FRAC_MIX;
      bk_pkg::FB_FRAC_NUMER_HI: wmask = bk_pkg::MASK_LOW6;
      default: wmask = bk_pkg::MASK_FULL;
    endcase
  endfunction

  function automatic logic in_bank(input logic [10:0] i);
    in_bank = (i >= bk_pkg::INNER_LIMIT_BYTE0) &&
              (i <= bk_pkg::FREQ_LOCK_DRAIN);
  endfunction

  // threshold in picoseconds whatever the programmed unit
  function automatic logic [31:0] to_ps(input logic [15:0] lim,
                                        input logic ns);
    if (ns) begin
      to_ps = {16'h0000, lim} * bk_pkg::PS_PER_NS;
    end else begin
      to_ps = {16'h0000, lim};
    end
  endfunction

  assign idx = avs_address[bk_pkg::ADDR_W-1:2];
  assign aligned = (avs_address[1:0] == 2'h0);

  // read mux; status is live state of this block
  // unaligned or unmapped reads give zero but still handshake
  always_comb begin
    status = 8'h00;
    status[bk_pkg::ST_PHASE_LOCK] = phase_locked;
    status[bk_pkg::ST_FREQ_LOCK] = freq_locked;
    status[bk_pkg::ST_FB_LOW] = fb_low_ff;
    rd_byte = 8'h00;
    if (!aligned) begin
      rd_byte = 8'h00;
    end else if (in_bank(idx)) begin
      rd_byte = regs_ff[idx];
    end else if (idx == bk_pkg::PHASE_SCALE) begin
      rd_byte = {scale_ff, 7'h00};
    end else if (idx == bk_pkg::BANK_STATUS) begin
      rd_byte = status;
    end
  end

  // bus: one wait cycle, write commits on the acknowledging edge
  always_comb begin
    nxt_state = state_ff;
    nxt_wait = wait_ff;
    nxt_rdata = rdata_ff;
    nxt_regs = regs_ff;
    nxt_scale = scale_ff;
    case (state_ff)
      bk_pkg::BUS_IDLE: begin
        if (avs_read || avs_write) begin
          nxt_state = bk_pkg::BUS_ACK;
          nxt_wait = 1'b0;
          nxt_rdata = avs_read ? {24'h000000, rd_byte} : '0;
        end
      end
      bk_pkg::BUS_ACK: begin
        nxt_state = bk_pkg::BUS_IDLE;
        nxt_wait = 1'b1;
        // only the acking edge commits, so a held write lands once
        if (avs_write && aligned && avs_byteenable[0]) begin
          if (in_bank(idx)) begin
            nxt_regs[idx] = avs_writedata[7:0] & wmask(idx);
          end else if (idx == bk_pkg::PHASE_SCALE) begin
            nxt_scale = avs_writedata[bk_pkg::SCALE_BIT];
          end
        end
      end
      default: begin
        nxt_state = bk_pkg::BUS_IDLE;
        nxt_wait = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= bk_pkg::BUS_IDLE;
      wait_ff <= 1'b1;
      rdata_ff <= '0;
      scale_ff <= 1'b0;
      for (int i = bk_pkg::INNER_LIMIT_BYTE0;
           i <= bk_pkg::FREQ_LOCK_DRAIN; i++) begin
        regs_ff[i] <= bk_pkg::RESET_BYTE;
      end
    end else begin
      state_ff <= nxt_state;
      wait_ff <= nxt_wait;
      rdata_ff <= nxt_rdata;
      scale_ff <= nxt_scale;
      regs_ff <= nxt_regs;
    end
  end

  // field assembly from the byte store
  always_comb begin
    nxt_coef = coef_ff;
    nxt_div = div_ff;
    nxt_lock = lock_ff;
    nxt_qual = qual_ff;
    // mantissa is a fraction, scaled by two^exponent downstream
    nxt_coef.a_mant = {regs_ff[bk_pkg::COEF_A_MANT_HI],
                       regs_ff[bk_pkg::COEF_A_MANT_LO]};
    nxt_coef.b_mant = {regs_ff[bk_pkg::COEF_B_EXP_MANT_TOP][1:0],
                       regs_ff[bk_pkg::COEF_B_MANT_MID],
                       regs_ff[bk_pkg::COEF_B_MANT_LOW_MIX][7:1]};
    nxt_coef.c_mant = {regs_ff[bk_pkg::COEF_C_EXP_MANT_TOP][0],
                       regs_ff[bk_pkg::COEF_C_MANT_MID],
                       regs_ff[bk_pkg::COEF_C_MANT_LO]};
    nxt_coef.d_mant = {regs_ff[bk_pkg::COEF_D_MANT_HI_MIX][6:0],
                       regs_ff[bk_pkg::COEF_D_MANT_LO]};
    nxt_coef.a_exp1 = regs_ff[bk_pkg::COEF_A_EXPONENTS][5:0];
    nxt_coef.a_exp2 = {regs_ff[bk_pkg::COEF_B_MANT_LOW_MIX][0],
                       regs_ff[bk_pkg::COEF_A_EXPONENTS][7:6]};
    nxt_coef.a_exp3 = regs_ff[bk_pkg::COEF_EXP_MIX][7:4];
    nxt_coef.b_exp = regs_ff[bk_pkg::COEF_B_EXP_MANT_TOP][6:2];
    nxt_coef.c_exp = regs_ff[bk_pkg::COEF_C_EXP_MANT_TOP][5:1];
    nxt_coef.d_exp = {regs_ff[bk_pkg::COEF_EXP_MIX][3:0],
                      regs_ff[bk_pkg::COEF_D_MANT_HI_MIX][7]};
    nxt_div.prescale = {regs_ff[bk_pkg::PRESCALE_DIV_BYTE3][5:0],
                        regs_ff[bk_pkg::PRESCALE_DIV_BYTE2],
                        regs_ff[bk_pkg::PRESCALE_DIV_BYTE1],
                        regs_ff[bk_pkg::PRESCALE_DIV_BYTE0]};
    nxt_div.fb_int = {regs_ff[bk_pkg::FB_INT_DIV_BYTE2][3:0],
                      regs_ff[bk_pkg::FB_INT_DIV_BYTE1],
                      regs_ff[bk_pkg::FB_INT_DIV_BYTE0]};
    nxt_div.frac_mod = {regs_ff[bk_pkg::FB_FRAC_MIXED][1:0],
                        regs_ff[bk_pkg::FB_FRAC_MODULUS_LO]};
    nxt_div.frac_num = {regs_ff[bk_pkg::FB_FRAC_NUMER_HI][5:0],
                        regs_ff[bk_pkg::FB_FRAC_MIXED][7:4]};
    nxt_lock.ph_limit = {regs_ff[bk_pkg::PHASE_LOCK_LIMIT_HI],
                         regs_ff[bk_pkg::PHASE_LOCK_LIMIT_LO]};
    nxt_lock.ph_scale_ns = scale_ff;
    nxt_lock.ph_limit_ps = to_ps(nxt_lock.ph_limit, scale_ff);
    nxt_lock.ph_fill = regs_ff[bk_pkg::PHASE_LOCK_FILL];
    nxt_lock.ph_drain = regs_ff[bk_pkg::PHASE_LOCK_DRAIN];
    nxt_lock.fr_limit_ps = {regs_ff[bk_pkg::FREQ_LOCK_LIMIT_BYTE2],
                            regs_ff[bk_pkg::FREQ_LOCK_LIMIT_BYTE1],
                            regs_ff[bk_pkg::FREQ_LOCK_LIMIT_BYTE0]};
    nxt_lock.fr_fill = regs_ff[bk_pkg::FREQ_LOCK_FILL];
    nxt_lock.fr_drain = regs_ff[bk_pkg::FREQ_LOCK_DRAIN];
    // tolerance limits pass through unchanged
    nxt_qual.inner = {regs_ff[bk_pkg::INNER_LIMIT_BYTE2][3:0],
                      regs_ff[bk_pkg::INNER_LIMIT_BYTE1],
                      regs_ff[bk_pkg::INNER_LIMIT_BYTE0]};
    nxt_qual.outer = {regs_ff[bk_pkg::OUTER_LIMIT_BYTE2][3:0],
                      regs_ff[bk_pkg::OUTER_LIMIT_BYTE1],
                      regs_ff[bk_pkg::OUTER_LIMIT_BYTE0]};
    nxt_qual.qualify_ms = {regs_ff[bk_pkg::QUALIFY_TIME_HI],
                           regs_ff[bk_pkg::QUALIFY_TIME_LO]};
    nxt_qual.recheck_ms = {regs_ff[bk_pkg::RECHECK_TIME_HI],
                           regs_ff[bk_pkg::RECHECK_TIME_LO]};
    // flag only: the divider still runs, software must keep it legal
    nxt_fb_low = (nxt_div.fb_int < bk_pkg::FB_INT_MIN);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      coef_ff <= '0;
      div_ff <= '0;
      lock_ff <= '0;
      qual_ff <= '0;
      fb_low_ff <= 1'b1;
    end else begin
      coef_ff <= nxt_coef;
      div_ff <= nxt_div;
      lock_ff <= nxt_lock;
      qual_ff <= nxt_qual;
      fb_low_ff <= nxt_fb_low;
    end
  end

  // millisecond enable that paces the qualify and recheck timers
  // free running, so a timer's first tick may come early
  always_comb begin
    nxt_ms = 1'b0;
    nxt_ms_cnt = ms_cnt_ff + 32'h00000001;
    if (ms_cnt_ff >= 32'(MS_CYCLES - 1)) begin
      nxt_ms_cnt = '0;
      nxt_ms = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ms_cnt_ff <= '0;
      ms_ff <= 1'b0;
    end else begin
      ms_cnt_ff <= nxt_ms_cnt;
      ms_ff <= nxt_ms;
    end
  end

  // a ratio lowered below the count wraps on the next input tick rather than finishing the count
  ratio_divider #(.CNT_W(30)) u_prescale (
    .clk(clk),
    .reset_n(reset_n),
    .tick_in(ref_tick),
    .ratio_m1(div_ff.prescale),
    .tick_out(prescale_tick)
  );

  ratio_divider #(.CNT_W(20)) u_feedback (
    .clk(clk),
    .reset_n(reset_n),
    .tick_in(vco_tick),
    .ratio_m1(div_ff.fb_int),
    .tick_out(feedback_tick)
  );

  lock_bucket #(.ERR_W(32), .FULL_LEVEL(LOCK_FULL)) u_phase_lock (
    .clk(clk),
    .reset_n(reset_n),
    .sample_valid(phase_err_valid),
    .err_mag(phase_err_ps),
    .limit(lock_ff.ph_limit_ps),
    .fill_rate(lock_ff.ph_fill),
    .drain_rate(lock_ff.ph_drain),
    .locked(phase_locked)
  );

  lock_bucket #(.ERR_W(24), .FULL_LEVEL(LOCK_FULL)) u_freq_lock (
    .clk(clk),
    .reset_n(reset_n),
    .sample_valid(freq_err_valid),
    .err_mag(freq_err_ps),
    .limit(lock_ff.fr_limit_ps),
    .fill_rate(lock_ff.fr_fill),
    .drain_rate(lock_ff.fr_drain),
    .locked(freq_locked)
  );

  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign ms_tick = ms_ff;
  assign coef = coef_ff;
  assign div_cfg = div_ff;
  assign lock_cfg = lock_ff;
  assign qual_cfg = qual_ff;
endmodule

// *** verilog/lock_bucket.sv ***
// Purpose: leaky-bucket lock detector with fill and drain rates
// Assumes: err_mag and limit share one unit
// Notes: lock sets at full level, drops only when bucket empties
`timescale 1ns/1ns
module lock_bucket #(
  parameter int ERR_W = 32,
  parameter int LEVEL_W = 16,
  parameter logic [15:0] FULL_LEVEL = 16'h0400
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // samples and settings
  input wire logic sample_valid,
  input wire logic [ERR_W-1:0] err_mag,
  input wire logic [ERR_W-1:0] limit,
  input wire logic [7:0] fill_rate,
  input wire logic [7:0] drain_rate,
  // result
  output logic locked
);
  if (ERR_W < 1 || LEVEL_W != 16 || FULL_LEVEL == 16'h0000) begin : g_chk
    $error("lock_bucket: bad parameters");
  end

  logic [LEVEL_W-1:0] level_ff, nxt_level;
  logic locked_ff, nxt_locked;
  logic [LEVEL_W:0] sum;

  always_comb begin
    nxt_level = level_ff;
    nxt_locked = locked_ff;
    sum = {1'b0, level_ff} + {9'h000, fill_rate};
    if (sample_valid) begin
      if (err_mag <= limit) begin
        nxt_level = (sum >= {1'b0, FULL_LEVEL}) ? FULL_LEVEL
                                                  : sum[LEVEL_W-1:0];
      end else if (level_ff > {8'h00, drain_rate}) begin
        nxt_level = level_ff - {8'h00, drain_rate};
      end else begin
        nxt_level = '0;
      end
    end
    // hysteresis avoids chatter near the limit
    if (nxt_level >= FULL_LEVEL) begin
      nxt_locked = 1'b1;
    end else if (nxt_level == '0) begin
      nxt_locked = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      level_ff <= '0;
      locked_ff <= 1'b0;
    end else begin
      level_ff <= nxt_level;
      locked_ff <= nxt_locked;
    end
  end

  assign locked = locked_ff;
endmodule

// *** verilog/ratio_divider.sv ***
// Purpose: divide an enable stream by a programmed value plus one
// Assumes: tick_in is a one-cycle pulse on clk
// Notes: a new ratio takes effect at the next wrap or when passed
`timescale 1ns/1ns
module ratio_divider #(
  parameter int CNT_W = 30
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // stream
  input wire logic tick_in,
  input wire logic [CNT_W-1:0] ratio_m1,
  output logic tick_out
);
  if (CNT_W < 1 || CNT_W > 32) begin : g_chk
    $error("ratio_divider: CNT_W out of range");
  end

  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic tick_ff, nxt_tick;

  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_tick = 1'b0;
    if (tick_in) begin
      // wrap at ratio_m1 gives ratio_m1 + 1 inputs per output
      if (cnt_ff >= ratio_m1) begin
        nxt_cnt = '0;
        nxt_tick = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick_out = tick_ff;
endmodule
